//--- design/fusc_uart.sv
// fifo uart core with a classic wishbone register slave
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RL1: sixteen-bit divisor divides clock, 1..65535
// RL2: divided clock over sixteen gives baud clock
// RL3: reset loads divisor with one
// RL4: host never writes divisor zero
// RL5: no baud output before divisor written
// RL6: read data holds until next read
// RL7: driver disable output gates external bus drivers
// RL8: no address strobe; address used directly
// RL9: receiver runs on clock with enable pulses
// RL10: single read, write and select strobe
// RL11: everything sampled on rising main clock
// RL12: fifo mode gives sixteen-byte fifos
// RL13: rx byte to holder or fifo by mode
// RL14: five to eight data bits
// RL15: one, one and half, two stops
// RL16: even, odd or no parity
// RL17: tx frames with start, parity, stops
// RL18: start bit not held is rejected
// RL19: interrupt on empty, errors, service; level readable
// RL20: four sources enabled apart, fixed priority
// RL21: active-low modem inputs and outputs
// RL22: loopback routes tx back to rx
// RL23: idle high, start low, lsb first
module fusc_uart
    import fusc_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [4:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_bus_driver_disable,
    input  wire logic        i_serial_rx,
    output logic             o_serial_tx,
    input  wire logic        i_clear_to_send_n,
    input  wire logic        i_set_ready_n,
    input  wire logic        i_ring_indicate_n,
    input  wire logic        i_carrier_detect_n,
    output logic             o_request_to_send_n,
    output logic             o_terminal_ready_n,
    output logic             o_baud_clock_out_n,
    output logic             o_irq
);

    fusc_baud_t  baud_reg, baud_next;
    fusc_tx_t    tx_reg, tx_next;
    fusc_rx_t    rx_reg, rx_next;
    fusc_host_t  host_reg, host_next;

    logic [7:0]  tx_mem [16], rx_mem [16];
    logic        rx_s1_reg, rx_s2_reg;
    logic [3:0]  ms_s1_reg, ms_s2_reg;

    logic        tick, tx_pop, tx_wr, rx_wr, rx_push, rx_ferr, div_wr;
    logic        rx_in, loop, thre;
    logic [2:0]  nbit_last;
    logic [5:0]  stop_last;
    logic [7:0]  rx_byte, iir_val, lsr_val;
    logic [3:0]  ms_now, iid;

    // shared decodes of line and modem control
    assign loop      = host_reg.mcr[MCR_LOOP];
    assign nbit_last = {1'b0, host_reg.lcr[1:0]} + 3'h4; // RL14
    assign rx_in     = loop ? tx_reg.line : rx_s2_reg; // RL22
    assign rx_byte   = rx_reg.sh >> (2'h3 - host_reg.lcr[1:0]);
    assign thre      = (host_reg.txc == 5'h00);

    // stop length in enable ticks
    assign stop_last = !host_reg.lcr[LCR_STOP] ? STOP_1 :
                       (host_reg.lcr[1:0] == 2'h0) ? STOP_15 : STOP_2; // RL15

    // modem inputs, or modem outputs when looped back
    assign ms_now = loop ? {host_reg.mcr[MCR_AUX2],
                            host_reg.mcr[MCR_AUX1],
                            host_reg.mcr[MCR_DTR],
                            host_reg.mcr[MCR_RTS]}
                         : ~ms_s2_reg; // RL21

    // interrupt source selection by fixed priority
    always_comb begin
        if (host_reg.ier[IER_LS] &&
            (host_reg.oe || host_reg.pe || host_reg.fe)) begin
            iid = IID_LS; // RL20
        end else if (host_reg.ier[IER_RX] &&
                     host_reg.rxc != 5'h00) begin
            iid = IID_RX; // RL20
        end else if (host_reg.ier[IER_THR] && host_reg.thre_int) begin
            iid = IID_THR; // RL20
        end else if (host_reg.ier[IER_MS] && host_reg.dmsr != 4'h0) begin
            iid = IID_MS; // RL20
        end else begin
            iid = IID_NONE;
        end
    end

    // status words as software reads them
    assign iir_val = {{2{host_reg.fifo_en}}, 1'b0, IRQ_LVL, iid}; // RL19
    assign lsr_val = {1'b0, thre && tx_reg.st == TX_IDLE, thre, 1'b0,
                      host_reg.fe, host_reg.pe, host_reg.oe,
                      host_reg.rxc != 5'h00};

    // input synchronisers for serial and modem pins
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            ms_s1_reg <= 4'hF;
            ms_s2_reg <= 4'hF;
        end else begin
            rx_s1_reg <= i_serial_rx; // RL11
            rx_s2_reg <= rx_s1_reg;
            ms_s1_reg <= {i_carrier_detect_n, i_ring_indicate_n,
                          i_set_ready_n, i_clear_to_send_n};
            ms_s2_reg <= ms_s1_reg;
        end
    end

    // baud divider and sixteen-tick bit clock
    always_comb begin
        baud_next = baud_reg;
        tick = 1'b0;
        if (host_reg.div_set) begin // RL5
            if (baud_reg.cnt >= host_reg.div - DIV_RST) begin
                tick = 1'b1; // RL1
                baud_next.cnt = 16'h0000;
                baud_next.sub = baud_reg.sub + 4'h1; // RL2
            end else begin
                baud_next.cnt = baud_reg.cnt + 16'h0001;
            end
        end
        if (div_wr) begin
            baud_next.cnt = 16'h0000;
        end
        baud_next.clk_n = !host_reg.div_set ||
                          baud_reg.sub >= OVS_HALF; // RL2 RL5
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            baud_reg <= BAUD_RST;
        end else begin
            baud_reg <= baud_next;
        end
    end

    // transmitter: start, data lsb first, parity, stops
    always_comb begin
        tx_next = tx_reg;
        tx_pop = 1'b0;
        if (tick) begin
            tx_next.cnt = tx_reg.cnt + 6'h01;
            case (tx_reg.st)
                TX_IDLE: begin
                    tx_next.cnt = 6'h00;
                    if (!thre) begin
                        tx_pop = 1'b1; // RL17
                        tx_next.sh = tx_mem[host_reg.txr];
                        tx_next.line = 1'b0; // RL23
                        tx_next.st = TX_START;
                    end
                end
                TX_START: begin
                    if (tx_reg.cnt[3:0] == OVS_LAST) begin
                        tx_next.cnt = 6'h00;
                        tx_next.bit_no = 3'h0;
                        tx_next.line = tx_reg.sh[0]; // RL23
                        tx_next.par = tx_reg.sh[0];
                        tx_next.sh = tx_reg.sh >> 1;
                        tx_next.st = TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_reg.cnt[3:0] == OVS_LAST) begin
                        tx_next.cnt = 6'h00;
                        if (tx_reg.bit_no != nbit_last) begin
                            tx_next.bit_no = tx_reg.bit_no + 3'h1;
                            tx_next.line = tx_reg.sh[0];
                            tx_next.par = tx_reg.par ^ tx_reg.sh[0];
                            tx_next.sh = tx_reg.sh >> 1;
                        end else if (host_reg.lcr[LCR_PEN]) begin
                            tx_next.line = tx_reg.par ^
                                           ~host_reg.lcr[LCR_EVEN]; // RL16
                            tx_next.st = TX_PAR;
                        end else begin
                            tx_next.line = 1'b1;
                            tx_next.st = TX_STOP;
                        end
                    end
                end
                TX_PAR: begin
                    if (tx_reg.cnt[3:0] == OVS_LAST) begin
                        tx_next.cnt = 6'h00;
                        tx_next.line = 1'b1; // RL23
                        tx_next.st = TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (tx_reg.cnt == stop_last) begin
                        tx_next.cnt = 6'h00;
                        tx_next.st = TX_IDLE; // RL15
                    end
                end
                default: tx_next = TX_RST;
            endcase
        end
        tx_next.pin = loop ? 1'b1 : tx_next.line; // RL22
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            tx_reg <= TX_RST;
        end else begin
            tx_reg <= tx_next;
        end
    end

    // receiver: mid-bit sampling on the tick enable
    always_comb begin
        rx_next = rx_reg;
        rx_push = 1'b0;
        rx_ferr = 1'b0;
        if (tick) begin // RL9
            rx_next.cnt = rx_reg.cnt + 4'h1;
            case (rx_reg.st)
                RX_IDLE: begin
                    rx_next.cnt = 4'h0;
                    if (!rx_in) begin
                        rx_next.st = RX_START; // RL23
                    end
                end
                RX_START: begin
                    if (rx_reg.cnt == OVS_MID) begin
                        rx_next.cnt = 4'h0;
                        rx_next.bit_no = 3'h0;
                        rx_next.par = 1'b0;
                        rx_next.perr = 1'b0;
                        rx_next.st = rx_in ? RX_IDLE : RX_DATA; // RL18
                    end
                end
                RX_DATA: begin
                    if (rx_reg.cnt == OVS_LAST) begin
                        rx_next.cnt = 4'h0;
                        rx_next.sh = {rx_in, rx_reg.sh[7:1]}; // RL23
                        rx_next.par = rx_reg.par ^ rx_in;
                        rx_next.bit_no = rx_reg.bit_no + 3'h1;
                        if (rx_reg.bit_no == nbit_last) begin
                            rx_next.st = host_reg.lcr[LCR_PEN] ?
                                         RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_reg.cnt == OVS_LAST) begin
                        rx_next.cnt = 4'h0;
                        rx_next.perr = rx_in != (rx_reg.par ^
                            ~host_reg.lcr[LCR_EVEN]); // RL16
                        rx_next.st = RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_reg.cnt == OVS_LAST) begin
                        rx_next.cnt = 4'h0;
                        rx_push = 1'b1;
                        rx_ferr = !rx_in;
                        rx_next.st = RX_IDLE;
                    end
                end
                default: rx_next = RX_RST;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rx_reg <= RX_RST;
        end else begin
            rx_reg <= rx_next;
        end
    end

    // byte storage of both fifos
    always_ff @(posedge i_core_clk) begin
        if (tx_wr) begin
            tx_mem[host_reg.txw] <= i_wb_dat[7:0];
        end
        if (rx_wr) begin
            rx_mem[host_reg.rxw] <= rx_byte; // RL13
        end
    end

    // wishbone slave, registers, fifo pointers and flags
    always_comb begin
        logic       acc;
        logic       rd;
        logic       wr;
        logic [2:0] a;
        logic [4:0] cap;
        logic       rx_rd;
        acc = i_wb_cyc && i_wb_stb && !host_reg.ack; // RL8 RL10
        rd = acc && !i_wb_we;
        wr = acc && i_wb_we;
        a = i_wb_adr[4:2];
        cap = host_reg.fifo_en ? FIFO_CAP : CHAR_CAP; // RL12
        host_next = host_reg;
        host_next.ack = acc;
        host_next.bus_driver_disable = !rd; // RL7
        div_wr = wr && a == REG_DIV[4:2] && i_wb_sel[1:0] != 2'b00;
        tx_wr = wr && i_wb_sel[0] && a == REG_DATA[4:2] &&
                host_reg.txc < cap;
        rx_rd = rd && a == REG_DATA[4:2] && host_reg.rxc != 5'h00;
        rx_wr = rx_push && host_reg.rxc < cap; // RL13
        // fifo pointers and fill counts
        host_next.txw = host_reg.txw + {3'h0, tx_wr};
        host_next.txr = host_reg.txr + {3'h0, tx_pop};
        host_next.txc = host_reg.txc + {4'h0, tx_wr} - {4'h0, tx_pop};
        host_next.rxw = host_reg.rxw + {3'h0, rx_wr};
        host_next.rxr = host_reg.rxr + {3'h0, rx_rd};
        host_next.rxc = host_reg.rxc + {4'h0, rx_wr} - {4'h0, rx_rd};
        // clears by software access come before hardware sets
        if (rd && a == REG_LSR[4:2]) begin
            host_next.oe = 1'b0;
            host_next.pe = 1'b0;
            host_next.fe = 1'b0;
        end
        if (rd && a == REG_MSR[4:2]) begin
            host_next.dmsr = 4'h0;
        end
        if ((rd && a == REG_IIR[4:2] && iid == IID_THR) || tx_wr) begin
            host_next.thre_int = 1'b0;
        end
        // register writes, byte lane 0 for byte registers
        if (wr && i_wb_sel[0]) begin
            case (a)
                REG_IER[4:2]: host_next.ier = i_wb_dat[3:0];
                REG_LCR[4:2]: host_next.lcr = i_wb_dat[4:0];
                REG_MCR[4:2]: host_next.mcr = i_wb_dat[4:0];
                REG_IIR[4:2]: begin
                    host_next.fifo_en = i_wb_dat[FCR_EN];
                    if (i_wb_dat[FCR_RXCLR] ||
                        i_wb_dat[FCR_EN] != host_reg.fifo_en) begin
                        host_next.rxw = 4'h0;
                        host_next.rxr = 4'h0;
                        host_next.rxc = 5'h00;
                    end
                    if (i_wb_dat[FCR_TXCLR] ||
                        i_wb_dat[FCR_EN] != host_reg.fifo_en) begin
                        host_next.txw = 4'h0;
                        host_next.txr = 4'h0;
                        host_next.txc = 5'h00;
                    end
                end
                default: ;
            endcase
        end
        if (div_wr) begin
            host_next.div_set = 1'b1; // RL5
            if (i_wb_sel[0]) begin
                host_next.div[7:0] = i_wb_dat[7:0]; // RL1
            end
            if (i_wb_sel[1]) begin
                host_next.div[15:8] = i_wb_dat[15:8];
            end
        end
        // hardware sets win over clears
        if (rx_push && !rx_wr) begin
            host_next.oe = 1'b1;
        end
        if (rx_wr) begin
            host_next.pe = host_next.pe || rx_reg.perr; // RL16
            host_next.fe = host_next.fe || rx_ferr;
        end
        if ((tx_pop && host_reg.txc == 5'h01) ||
            (wr && i_wb_sel[0] && a == REG_IER[4:2] &&
             i_wb_dat[IER_THR] && host_next.txc == 5'h00)) begin
            host_next.thre_int = 1'b1; // RL19
        end
        host_next.dmsr = host_next.dmsr | (ms_now ^ host_reg.ms_prev);
        host_next.ms_prev = ms_now;
        // read data, held until the next read
        if (rd) begin
            case (a)
                REG_DATA[4:2]: host_next.rdat = {8'h00,
                                                 rx_mem[host_reg.rxr]};
                REG_IER[4:2]:  host_next.rdat = {12'h000, host_reg.ier};
                REG_IIR[4:2]:  host_next.rdat = {8'h00, iir_val};
                REG_LCR[4:2]:  host_next.rdat = {11'h000, host_reg.lcr};
                REG_MCR[4:2]:  host_next.rdat = {11'h000, host_reg.mcr};
                REG_LSR[4:2]:  host_next.rdat = {8'h00, lsr_val};
                REG_MSR[4:2]:  host_next.rdat = {8'h00, ms_now,
                                                 host_reg.dmsr};
                default:       host_next.rdat = host_reg.div;
            endcase // RL6
        end
        // interrupt line and modem outputs
        host_next.irq = (iid != IID_NONE) ? IRQ_LVL : ~IRQ_LVL; // RL19
        host_next.rts_n = host_next.mcr[MCR_LOOP] ||
                          !host_next.mcr[MCR_RTS]; // RL21
        host_next.dtr_n = host_next.mcr[MCR_LOOP] ||
                          !host_next.mcr[MCR_DTR]; // RL21
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            host_reg <= HOST_RST; // RL3
        end else begin
            host_reg <= host_next; // RL11
        end
    end

    // outputs straight from flip-flops
    assign o_wb_dat             = {16'h0000, host_reg.rdat}; // RL6
    assign o_wb_ack             = host_reg.ack;
    assign o_bus_driver_disable = host_reg.bus_driver_disable; // RL7
    assign o_serial_tx          = tx_reg.pin;
    assign o_request_to_send_n  = host_reg.rts_n;
    assign o_terminal_ready_n   = host_reg.dtr_n;
    assign o_baud_clock_out_n   = baud_reg.clk_n; // RL2
    assign o_irq                = host_reg.irq;

endmodule // fusc_uart
`default_nettype wire

//--- design/fusc_pkg.sv
// constants, types and reset values of the fifo uart core
package fusc_pkg;
    // register byte offsets
    localparam logic [4:0] REG_DATA = 5'h00;
    localparam logic [4:0] REG_IER  = 5'h04;
    localparam logic [4:0] REG_IIR  = 5'h08;
    localparam logic [4:0] REG_LCR  = 5'h0C;
    localparam logic [4:0] REG_MCR  = 5'h10;
    localparam logic [4:0] REG_LSR  = 5'h14;
    localparam logic [4:0] REG_MSR  = 5'h18;
    localparam logic [4:0] REG_DIV  = 5'h1C;
    // interrupt enable bits
    localparam int IER_RX  = 0;
    localparam int IER_THR = 1;
    localparam int IER_LS  = 2;
    localparam int IER_MS  = 3;
    // line control fields, word length in bits 1:0
    localparam int LCR_STOP = 2;
    localparam int LCR_PEN  = 3;
    localparam int LCR_EVEN = 4;
    // modem control bits
    localparam int MCR_DTR  = 0;
    localparam int MCR_RTS  = 1;
    localparam int MCR_AUX1 = 2;
    localparam int MCR_AUX2 = 3;
    localparam int MCR_LOOP = 4;
    // fifo control bits
    localparam int FCR_EN    = 0;
    localparam int FCR_RXCLR = 1;
    localparam int FCR_TXCLR = 2;
    // interrupt identities and reported level
    localparam logic [3:0] IID_NONE = 4'h1;
    localparam logic [3:0] IID_LS   = 4'h6;
    localparam logic [3:0] IID_RX   = 4'h4;
    localparam logic [3:0] IID_THR  = 4'h2;
    localparam logic [3:0] IID_MS   = 4'h0;
    localparam logic       IRQ_LVL  = 1'b1;
    // reset values
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [4:0]  MCR_RST = 5'h00;
    // fifo sizes
    localparam logic [4:0] FIFO_CAP = 5'h10;
    localparam logic [4:0] CHAR_CAP = 5'h01;
    // oversampling: sixteen enables per bit
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID  = 4'h7;
    localparam logic [3:0] OVS_HALF = 4'h8;
    localparam logic [5:0] STOP_1   = 6'h0F;
    localparam logic [5:0] STOP_15  = 6'h17;
    localparam logic [5:0] STOP_2   = 6'h1F;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_PAR   = 3'b011,
        TX_STOP  = 3'b100
    } fusc_tx_st_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b010,
        RX_PAR   = 3'b011,
        RX_STOP  = 3'b100
    } fusc_rx_st_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic [3:0]  sub;
        logic        clk_n;
    } fusc_baud_t;

    typedef struct packed {
        fusc_tx_st_t st;
        logic [5:0]  cnt;
        logic [2:0]  bit_no;
        logic [7:0]  sh;
        logic        par;
        logic        line;
        logic        pin;
    } fusc_tx_t;

    typedef struct packed {
        fusc_rx_st_t st;
        logic [3:0]  cnt;
        logic [2:0]  bit_no;
        logic [7:0]  sh;
        logic        par;
        logic        perr;
    } fusc_rx_t;

    typedef struct packed {
        logic [15:0] div;
        logic        div_set;
        logic [3:0]  ier;
        logic [4:0]  lcr;
        logic [4:0]  mcr;
        logic        fifo_en;
        logic [3:0]  txw;
        logic [3:0]  txr;
        logic [4:0]  txc;
        logic [3:0]  rxw;
        logic [3:0]  rxr;
        logic [4:0]  rxc;
        logic        oe;
        logic        pe;
        logic        fe;
        logic        thre_int;
        logic [3:0]  dmsr;
        logic [3:0]  ms_prev;
        logic        ack;
        logic [15:0] rdat;
        logic        bus_driver_disable;
        logic        irq;
        logic        rts_n;
        logic        dtr_n;
    } fusc_host_t;

    localparam fusc_baud_t BAUD_RST = '{cnt: 16'h0000, sub: 4'h0,
                                        clk_n: 1'b1};
    localparam fusc_tx_t TX_RST = '{st: TX_IDLE, cnt: 6'h00,
        bit_no: 3'h0, sh: 8'h00, par: 1'b0, line: 1'b1, pin: 1'b1};
    localparam fusc_rx_t RX_RST = '{st: RX_IDLE, cnt: 4'h0,
        bit_no: 3'h0, sh: 8'h00, par: 1'b0, perr: 1'b0};
    localparam fusc_host_t HOST_RST = '{div: DIV_RST, mcr: MCR_RST,
        bus_driver_disable: 1'b1, irq: ~IRQ_LVL, rts_n: 1'b1, dtr_n: 1'b1,
        default: '0};
endpackage

//--- verif/fusc_uart_checker.sv
// port assertions for the fifo uart core
`timescale 1ns/1ps
`default_nettype none
module fusc_uart_checker (
    input wire logic        i_core_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [4:0]  i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        o_bus_driver_disable,
    input wire logic        o_serial_tx,
    input wire logic        o_baud_clock_out_n
);
    logic div_seen_reg, div_seen_next;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    // remember whether a divisor write was ever taken
    always_comb begin
        div_seen_next = div_seen_reg | (i_wb_cyc & i_wb_stb & ~o_wb_ack
            & i_wb_we & (i_wb_adr[4:2] == 3'h7));
    end
    always_ff @(posedge i_core_clk) begin
        div_seen_reg <= i_sys_rst ? 1'b0 : div_seen_next;
    end
    property p_ack_take; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
    endproperty
    a_ack_take: assert property (p_ack_take) else $error("ack late");
    property p_ack_one; o_wb_ack |=> !o_wb_ack; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack long");
    property p_ack_cause; o_wb_ack |-> $past(i_wb_stb); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack stray");
    property p_bus_driver_disable; !o_bus_driver_disable |-> o_wb_ack && !i_wb_we;
    endproperty
    a_bus_driver_disable: assert property (p_bus_driver_disable) else $error("bus_driver_disable low");
    property p_rdat; $changed(o_wb_dat) |-> o_wb_ack && !i_wb_we;
    endproperty
    a_rdat: assert property (p_rdat) else $error("read data moved");
    property p_quiet; !div_seen_reg |-> o_baud_clock_out_n; endproperty
    a_quiet: assert property (p_quiet) else $error("baud early");
    property p_baud; $fell(o_baud_clock_out_n) |=> !o_baud_clock_out_n [*7];
    endproperty
    a_baud: assert property (p_baud) else $error("baud half short");
    property p_tx_bit; $fell(o_serial_tx) |=> !o_serial_tx [*8]; endproperty
    a_tx_bit: assert property (p_tx_bit) else $error("tx bit short");
endmodule // fusc_uart_checker
bind fusc_uart fusc_uart_checker u_chk (.*);
`default_nettype wire

//--- verif/fusc_peer.sv
// remote serial device playing frames onto the receive line
`timescale 1ns/1ps
`default_nettype none
module fusc_peer (
    input  wire logic       i_core_clk,
    input  wire logic       i_go,
    input  wire logic [9:0] i_frm,
    input  wire logic [7:0] i_len,
    output logic            o_line
);
    logic [9:0] sh_reg = 10'h3FF;
    logic [7:0] pos_reg = 8'h00;
    logic [7:0] len_reg = 8'h00;
    // one bit per sixteen clocks, lsb first, idle high after
    always_ff @(posedge i_core_clk) begin
        if (i_go) begin
            {sh_reg, pos_reg, len_reg} <= {i_frm, 8'h00, i_len};
        end else if (pos_reg < len_reg) begin
            pos_reg <= pos_reg + 8'h01;
        end
    end
    assign o_line = (pos_reg < len_reg) ? sh_reg[pos_reg[7:4]] : 1'b1;
endmodule // fusc_peer
`default_nettype wire

//--- verif/fusc_uart_tb.sv
// self-checking bench for the fifo uart core
`timescale 1ns/1ps
`default_nettype none
module fusc_uart_tb
    import fusc_pkg::*;
;
    logic        i_core_clk = 1'b0, i_sys_rst = 1'b1, go = 1'b0;
    logic        i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic [4:0]  i_wb_adr = 5'h00;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat, q;
    logic [3:0]  i_wb_sel = 4'h3;
    logic [9:0]  frm = 10'h3FF;
    logic [7:0]  len = 8'h00;
    logic        i_clear_to_send_n = 1'b1, i_set_ready_n = 1'b1;
    logic        i_ring_indicate_n = 1'b1, i_carrier_detect_n = 1'b1;
    logic        o_wb_ack, o_bus_driver_disable, i_serial_rx, o_serial_tx;
    logic        o_request_to_send_n, o_terminal_ready_n;
    logic        o_baud_clock_out_n, o_irq;
    int          err_total = 0, check_count = 0;
    fusc_uart DUT (.*);
    fusc_peer u_peer (.i_core_clk(i_core_clk), .i_go(go), .i_frm(frm),
        .i_len(len), .o_line(i_serial_rx));
    always #12.5 i_core_clk = ~i_core_clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one classic cycle, held until ack is seen
    task automatic wb(input logic w, input logic [4:0] a, input int d);
        int t;
        t = 0;
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, w, a, d};
        do @(posedge i_core_clk); while (o_wb_ack !== 1'b1 && t++ < 99);
        if (t > 99) err_total++;
        q = o_wb_dat;
        {i_wb_cyc, i_wb_stb} <= 2'b00;
        @(posedge i_core_clk);
    endtask
    task automatic send(input logic [7:0] b, input logic [7:0] n);
        {frm, len, go} <= {1'b1, b, 1'b0, n, 1'b1};
        @(posedge i_core_clk);
        go <= 1'b0;
        repeat (n + 12) @(posedge i_core_clk);
    endtask
    task automatic t_reset();
        chk({o_bus_driver_disable, o_serial_tx, o_baud_clock_out_n}, 7);
        wb(1'b0, REG_DIV, 0);
        chk(q, 1);
        wb(1'b1, REG_LCR, 3);
        chk(o_wb_dat, 1);
        wb(1'b1, REG_DIV, 1);
        $display("reset test done");
    endtask
    task automatic t_tx();
        int t;
        for (int wl = 0; wl < 4; wl++) begin
            wb(1'b1, REG_LCR, wl + 'h08);
            wb(1'b1, REG_DATA, 'hA5);
            t = 0;
            while (o_serial_tx && t++ < 400) @(posedge i_core_clk);
            repeat (8) @(posedge i_core_clk);
            for (int b = 0; b < wl + 8; b++) begin
                t = (b == 0) ? 0 : (b == wl + 6) ?
                    ~^('hA5 & ((1 << (wl + 5)) - 1)) :
                    (b > wl + 5) ? 1 : ('hA5 >> (b - 1)) & 1;
                chk(o_serial_tx, t);
                repeat (16) @(posedge i_core_clk);
            end
        end
        $display("tx test done");
    endtask
    task automatic t_rx();
        wb(1'b1, REG_LCR, 3);
        wb(1'b1, REG_IER, 1);
        send(8'hFF, 8'h04);
        send(8'h3C, 8'hA0);
        chk(o_irq, 1);
        wb(1'b0, REG_IIR, 0);
        chk(q[3:0], IID_RX);
        wb(1'b0, REG_DATA, 0);
        chk(q, 'h3C);
        chk(o_irq, 0);
        wb(1'b1, REG_IIR, 1);
        for (int i = 0; i < 17; i++) send(8'(i + 64), 8'hA0);
        wb(1'b0, REG_LSR, 0);
        chk(q[1:0], 3);
        for (int i = 0; i < 16; i++) begin
            wb(1'b0, REG_DATA, 0);
            chk(q, i + 64);
        end
        $display("rx test done");
    endtask
    task automatic t_loop();
        wb(1'b1, REG_MCR, 'h13);
        wb(1'b1, REG_DATA, 'h5A);
        repeat (90) @(posedge i_core_clk);
        chk(o_serial_tx, 1);
        repeat (110) @(posedge i_core_clk);
        wb(1'b0, REG_DATA, 0);
        chk(q, 'h5A);
        wb(1'b1, REG_MCR, 3);
        i_clear_to_send_n <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        wb(1'b0, REG_MSR, 0);
        chk({q[4], o_request_to_send_n, o_terminal_ready_n}, 4);
        $display("loop test done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_core_clk);
        t_reset();
        t_tx();
        t_rx();
        t_loop();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge i_core_clk);
        err_total++;
        final_report();
    end
endmodule // fusc_uart_tb
`default_nettype wire
